// File: rtl/pec_pkg.sv
// Contract
// - core events count only while core active
// - unhalted cycle events stop on halt, despite snoops
// - unit-mask bits 15:14 = 11 count all cores
// - bus data-ready mask 20H counts all agents
// - code 30H counts second-level reject cycles
// - code 32H counts second-level idle cycles
// - 3C/00H counts unhalted core clock cycles
// - 3C/01H counts bus cycles while unhalted
// - 3C/02H counts bus cycles, other core halted
// - 4FH counts prefetch requests, resubmits included
// - 78H/01H counts data cache share snoops
// - 7DH counts bus cycles with nothing outstanding
// - 77H counts snoop responses seen on bus
// - full-line writes count cached and uncached writes
// - remote writes uncached; local writes cached only
// - memctl reads only; home reads add inv-to-excl
// - uncore bandwidth events under 20H, 2CH, 2FH
package pec_pkg;
    localparam int PEC_NUM_CTR = 2;
    localparam int PEC_DW      = 32;
    localparam int PEC_AW      = 8;

    // register map, one word per register
    localparam logic [7:0] PEC_EVTSEL_BASE = 8'h00;
    localparam logic [7:0] PEC_CTR_BASE    = 8'h20;
    localparam logic [7:0] PEC_STATUS_ADDR = 8'h40;
    localparam logic [7:0] PEC_REG_STRIDE  = 8'h04;

    // event-select field layout
    localparam int PEC_CODE_LSB = 0;
    localparam int PEC_MASK_LSB = 8;
    localparam int PEC_SPEC_LSB = 14;
    localparam int PEC_EN_BIT   = 22;

    // event codes
    localparam logic [7:0] PEC_EV_L2_REJECT = 8'h30;
    localparam logic [7:0] PEC_EV_L2_IDLE   = 8'h32;
    localparam logic [7:0] PEC_EV_UNHALTED  = 8'h3C;
    localparam logic [7:0] PEC_EV_L1_PREF   = 8'h4F;
    localparam logic [7:0] PEC_EV_SHR_SNOOP = 8'h78;
    localparam logic [7:0] PEC_EV_BUS_IDLE  = 8'h7D;
    localparam logic [7:0] PEC_EV_BUS_SNOOP = 8'h77;
    localparam logic [7:0] PEC_EV_BUS_DRDY  = 8'h62;
    localparam logic [7:0] PEC_EV_HOME_REQ  = 8'h20;
    localparam logic [7:0] PEC_EV_MC_READ   = 8'h2C;
    localparam logic [7:0] PEC_EV_MC_WRITE  = 8'h2F;

    // unit masks
    localparam logic [7:0] PEC_UM_00      = 8'h00;
    localparam logic [7:0] PEC_UM_01      = 8'h01;
    localparam logic [7:0] PEC_UM_02      = 8'h02;
    localparam logic [7:0] PEC_UM_ALL_AG  = 8'h20;
    localparam logic [1:0] PEC_SPEC_ALL   = 2'h3;
    localparam int PEC_HOME_LRD = 0;
    localparam int PEC_HOME_RRD = 1;
    localparam int PEC_HOME_LWR = 2;
    localparam int PEC_HOME_RWR = 3;

    localparam logic [7:0] PEC_BUS_RATIO = 8'h04;

    // condition inputs from core and uncore
    typedef struct packed {
        logic core_running;
        logic core_snooped;
        logic other_halted;
        logic l2_reject;
        logic l2_reject_other;
        logic l2_idle;
        logic l2_idle_other;
        logic first_level_prefetch_requests;
        logic data_cache_share_snoops;
        logic bus_idle;
        logic bus_snoop_resp;
        logic bus_drdy;
        logic bus_drdy_other;
        logic mc_write_cached_wb;
        logic mc_write_uncached;
        logic home_remote_write_uncached;
        logic home_local_write_cached;
        logic home_local_write_uncached;
        logic mc_normal_read;
        logic home_local_read;
        logic home_remote_read;
        logic home_local_inv_excl;
        logic home_remote_inv_excl;
    } pec_events_t;

    typedef struct packed {
        logic       en;
        logic [5:0] rsvd;
        logic [7:0] umask;
        logic [7:0] code;
    } pec_evtsel_t;

    typedef struct packed {
        logic [7:0] cnt;
        logic       tick;
    } pec_div_st_t;

    typedef struct packed {
        pec_evtsel_t [PEC_NUM_CTR-1:0]             evtsel;
        logic [PEC_NUM_CTR-1:0][PEC_DW-1:0]        ctr;
        logic [PEC_DW-1:0]                         rdata;
        logic                                      active;
        logic                                      running;
    } pec_state_t;
endpackage

// File: rtl/pec_bus_div.sv
// bus clock enable: one-cycle pulse every RATIO core cycles
module pec_bus_div #(
    parameter logic [7:0] RATIO = pec_pkg::PEC_BUS_RATIO
) (
    // clock and reset
    input  wire logic core_clk_i,
    input  wire logic reset_i,
    // enable out
    output logic      tick_o
);
    import pec_pkg::*;

    pec_div_st_t st_r;
    pec_div_st_t st_nxt;

    // count down so the ratio can change without a wide compare
    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (st_r.cnt == 8'h00) begin
            st_nxt.cnt  = RATIO - 8'h01;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt - 8'h01;
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick_o = st_r.tick;
endmodule

// File: rtl/pec_evt_decode.sv
// maps one event-select setting and the condition inputs to an increment
module pec_evt_decode (
    // setting and conditions
    input  wire pec_pkg::pec_evtsel_t evtsel_i,
    input  wire pec_pkg::pec_events_t ev_i,
    input  wire logic                 bus_tick_i,
    // amount to add this cycle
    output logic [2:0]                inc_o
);
    import pec_pkg::*;

    logic active;
    logic allcore;
    logic [7:0] um;

    // core events are gated by activity; uncore events are not
    always_comb begin
        active  = ev_i.core_running | ev_i.core_snooped;
        um      = evtsel_i.umask;
        allcore = (um[PEC_SPEC_LSB-PEC_MASK_LSB +: 2] == PEC_SPEC_ALL);
        inc_o   = 3'h0;
        if (evtsel_i.en) begin
            case (evtsel_i.code)
                PEC_EV_L2_REJECT: begin
                    inc_o = {2'h0, active & (ev_i.l2_reject | (allcore & ev_i.l2_reject_other))};
                end
                PEC_EV_L2_IDLE: begin
                    inc_o = {2'h0, active & (ev_i.l2_idle | (allcore & ev_i.l2_idle_other))};
                end
                PEC_EV_UNHALTED: begin
                    // halted core never counts here, snooped or not
                    if (ev_i.core_running) begin
                        case (um)
                            PEC_UM_00: inc_o = 3'h1;
                            PEC_UM_01: inc_o = {2'h0, bus_tick_i};
                            PEC_UM_02: inc_o = {2'h0, bus_tick_i & ev_i.other_halted};
                            default:   inc_o = 3'h0;
                        endcase
                    end
                end
                PEC_EV_L1_PREF: begin
                    if (um == PEC_UM_00) begin
                        inc_o = {2'h0, active & ev_i.first_level_prefetch_requests};
                    end
                end
                PEC_EV_SHR_SNOOP: begin
                    if (um == PEC_UM_01) begin
                        inc_o = {2'h0, active & ev_i.data_cache_share_snoops};
                    end
                end
                PEC_EV_BUS_IDLE: begin
                    if (um == PEC_UM_00) begin
                        inc_o = {2'h0, active & bus_tick_i & ev_i.bus_idle};
                    end
                end
                PEC_EV_BUS_SNOOP: begin
                    if (um == PEC_UM_00) begin
                        inc_o = {2'h0, active & ev_i.bus_snoop_resp};
                    end
                end
                PEC_EV_BUS_DRDY: begin
                    inc_o = {2'h0, active & (ev_i.bus_drdy | ((um == PEC_UM_ALL_AG) & ev_i.bus_drdy_other))};
                end
                PEC_EV_HOME_REQ: begin
                    // uncached local writebacks are deliberately not an input term
                    inc_o = {2'h0, um[PEC_HOME_LRD] & (ev_i.home_local_read | ev_i.home_local_inv_excl)}
                          + {2'h0, um[PEC_HOME_RRD] & (ev_i.home_remote_read | ev_i.home_remote_inv_excl)}
                          + {2'h0, um[PEC_HOME_LWR] & ev_i.home_local_write_cached}
                          + {2'h0, um[PEC_HOME_RWR] & ev_i.home_remote_write_uncached};
                end
                PEC_EV_MC_READ: begin
                    inc_o = {2'h0, um[0] & ev_i.mc_normal_read};
                end
                PEC_EV_MC_WRITE: begin
                    inc_o = {2'h0, um[0] & ev_i.mc_write_cached_wb}
                          + {2'h0, um[0] & ev_i.mc_write_uncached};
                end
                default: inc_o = 3'h0;
            endcase
        end
    end
endmodule

// File: rtl/pec_counter_logic.sv
// performance-event counter bank with a simple register port
//
// Our own choices: the plain strobed port and the register addresses.
module pec_counter_logic #(
    parameter logic [7:0] BUS_RATIO = pec_pkg::PEC_BUS_RATIO
) (
    // clock and reset
    input  wire logic                        core_clk_i,
    input  wire logic                        reset_i,
    // register port
    input  wire logic [pec_pkg::PEC_AW-1:0]  addr_i,
    input  wire logic [pec_pkg::PEC_DW-1:0]  wdata_i,
    input  wire logic                        wr_i,
    input  wire logic                        rd_i,
    output logic [pec_pkg::PEC_DW-1:0]       rdata_o,
    // event conditions
    input  wire pec_pkg::pec_events_t        ev_i,
    // state view
    output logic                             core_active_o
);
    import pec_pkg::*;

    pec_state_t st_r;
    pec_state_t st_nxt;
    logic       bus_tick;
    logic [PEC_NUM_CTR-1:0][2:0] inc;

    // bus-rate enable shared by every counter
    pec_bus_div #(
        .RATIO (BUS_RATIO)
    ) u_div (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .tick_o     (bus_tick)
    );

    // one decoder per counter
    for (genvar g = 0; g < PEC_NUM_CTR; g++) begin : g_dec
        pec_evt_decode u_dec (
            .evtsel_i   (st_r.evtsel[g]),
            .ev_i       (ev_i),
            .bus_tick_i (bus_tick),
            .inc_o      (inc[g])
        );
    end

    // counting, register writes and reads; a software write beats a count
    always_comb begin
        st_nxt         = st_r;
        st_nxt.rdata   = '0;
        st_nxt.active  = ev_i.core_running | ev_i.core_snooped;
        st_nxt.running = ev_i.core_running;
        for (int i = 0; i < PEC_NUM_CTR; i++) begin
            st_nxt.ctr[i] = st_r.ctr[i] + PEC_DW'(inc[i]);
            if (wr_i && addr_i == PEC_EVTSEL_BASE + PEC_REG_STRIDE * 8'(i)) begin
                st_nxt.evtsel[i] = pec_evtsel_t'(wdata_i[PEC_EN_BIT:0]);
                st_nxt.evtsel[i].rsvd = '0; // reserved bits never hold a one
            end
            if (wr_i && addr_i == PEC_CTR_BASE + PEC_REG_STRIDE * 8'(i)) begin
                st_nxt.ctr[i] = wdata_i;
            end
            if (rd_i && addr_i == PEC_EVTSEL_BASE + PEC_REG_STRIDE * 8'(i)) begin
                st_nxt.rdata = {{(PEC_DW-PEC_EN_BIT-1){1'b0}}, st_r.evtsel[i]};
            end
            if (rd_i && addr_i == PEC_CTR_BASE + PEC_REG_STRIDE * 8'(i)) begin
                st_nxt.rdata = st_r.ctr[i];
            end
        end
        if (rd_i && addr_i == PEC_STATUS_ADDR) begin
            st_nxt.rdata = {{(PEC_DW-2){1'b0}}, st_r.running, st_r.active};
        end
    end

    // state register; reset leaves every select disabled
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata_o       = st_r.rdata;
    assign core_active_o = st_r.active;

    // helper view of counter 0 for the checks below
    pec_evtsel_t     es0;
    logic            nowr0;
    logic [7:0]      code0;
    logic [7:0]      um0;
    assign es0   = st_r.evtsel[0];
    assign code0 = es0.code;
    assign um0   = es0.umask;
    assign nowr0 = !(wr_i && addr_i == PEC_CTR_BASE);

    // helper view of counter 1; the bench runs the remaining core codes here
    pec_evtsel_t     es1;
    logic            nowr1;
    logic            act1;
    logic [7:0]      code1;
    logic [7:0]      um1;
    assign es1   = st_r.evtsel[1];
    assign code1 = es1.code;
    assign um1   = es1.umask;
    assign act1  = ev_i.core_running | ev_i.core_snooped;
    assign nowr1 = !(wr_i && addr_i == PEC_CTR_BASE + PEC_REG_STRIDE);

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    sequence s_held;
        st_r.ctr[0] == $past(st_r.ctr[0]);
    endsequence

    sequence s_bump1;
        st_r.ctr[0] == $past(st_r.ctr[0]) + 32'h1;
    endsequence

    sequence s_bump2;
        st_r.ctr[0] == $past(st_r.ctr[0]) + 32'h2;
    endsequence

    sequence s_held_c1;
        st_r.ctr[1] == $past(st_r.ctr[1]);
    endsequence

    sequence s_bump1_c1;
        st_r.ctr[1] == $past(st_r.ctr[1]) + 32'h1;
    endsequence

    idle_gate_a: assert property (
        (es0.en && code0 == PEC_EV_L2_REJECT && !ev_i.core_running && !ev_i.core_snooped && nowr0)
        |=> s_held)
        else $error("core event counted while core inactive");

    halt_stop_a: assert property (
        (es0.en && code0 == PEC_EV_UNHALTED && !ev_i.core_running && ev_i.core_snooped && nowr0)
        |=> s_held)
        else $error("unhalted cycles counted on halted core");

    all_core_a: assert property (
        (es0.en && code0 == PEC_EV_L2_REJECT && um0[7:6] == PEC_SPEC_ALL && ev_i.core_running
         && !ev_i.l2_reject && ev_i.l2_reject_other && nowr0)
        |=> s_bump1)
        else $error("all-core qualification ignored");

    drdy_agents_a: assert property (
        (es0.en && code0 == PEC_EV_BUS_DRDY && um0 == PEC_UM_ALL_AG && ev_i.core_running
         && !ev_i.bus_drdy && ev_i.bus_drdy_other && nowr0)
        |=> s_bump1)
        else $error("data-ready from other agent missed");

    core_cycles_a: assert property (
        (es0.en && code0 == PEC_EV_UNHALTED && um0 == PEC_UM_00 && ev_i.core_running && nowr0) [*3]
        |=> s_bump1)
        else $error("core cycle count did not advance");

    ref_cycles_a: assert property (
        (es0.en && code0 == PEC_EV_UNHALTED && um0 == PEC_UM_01 && ev_i.core_running && nowr0)
        |=> st_r.ctr[0] == $past(st_r.ctr[0]) + 32'($past(bus_tick)))
        else $error("reference cycles not tied to bus tick");

    serial_cyc_a: assert property (
        (es0.en && code0 == PEC_EV_UNHALTED && um0 == PEC_UM_02 && ev_i.core_running
         && !ev_i.other_halted && nowr0)
        |=> s_held)
        else $error("serial cycles counted with other core running");

    bus_idle_a: assert property (
        (es0.en && code0 == PEC_EV_BUS_IDLE && um0 == PEC_UM_00 && ev_i.core_running
         && ev_i.bus_idle && !bus_tick && nowr0)
        |=> s_held)
        else $error("bus idle counted off a bus cycle");

    full_writes_a: assert property (
        (es0.en && code0 == PEC_EV_MC_WRITE && um0[0] && ev_i.mc_write_cached_wb
         && ev_i.mc_write_uncached && nowr0)
        |=> s_bump2)
        else $error("full-line writes undercounted");

    local_wr_a: assert property (
        (es0.en && code0 == PEC_EV_HOME_REQ && um0 == 8'h04 && !ev_i.home_local_write_cached && nowr0)
        |=> s_held)
        else $error("local write event counted uncached writeback");

    mc_reads_a: assert property (
        (es0.en && code0 == PEC_EV_MC_READ && !ev_i.mc_normal_read && nowr0)
        |=> s_held)
        else $error("memory read event counted non-read");

    disabled_a: assert property (
        (!es0.en && nowr0) [*2] |=> s_held)
        else $error("disabled counter moved");

    idle_tick_a: assert property (
        (es0.en && code0 == PEC_EV_BUS_IDLE && um0 == PEC_UM_00 && ev_i.core_running
         && ev_i.bus_idle && bus_tick && nowr0)
        |=> s_bump1)
        else $error("idle bus cycle not counted");

    rej_cycles_a: assert property (
        (es1.en && code1 == PEC_EV_L2_REJECT && act1 && ev_i.l2_reject && nowr1)
        |=> s_bump1_c1)
        else $error("reject cycle not counted");

    idle_cycles_a: assert property (
        (es1.en && code1 == PEC_EV_L2_IDLE && act1 && ev_i.l2_idle && nowr1)
        |=> s_bump1_c1)
        else $error("second-level idle cycle not counted");

    pref_req_a: assert property (
        (es1.en && code1 == PEC_EV_L1_PREF && um1 == PEC_UM_00 && act1
         && ev_i.first_level_prefetch_requests && nowr1)
        |=> s_bump1_c1)
        else $error("prefetch request not counted");

    pref_mask_a: assert property (
        (es1.en && code1 == PEC_EV_L1_PREF && um1 != PEC_UM_00 && nowr1)
        |=> s_held_c1)
        else $error("prefetch counted under wrong unit mask");

    share_snoop_a: assert property (
        (es1.en && code1 == PEC_EV_SHR_SNOOP && um1 == PEC_UM_01 && act1
         && ev_i.data_cache_share_snoops && nowr1)
        |=> s_bump1_c1)
        else $error("share snoop not counted");

    snoop_resp_a: assert property (
        (es1.en && code1 == PEC_EV_BUS_SNOOP && um1 == PEC_UM_00 && act1
         && ev_i.bus_snoop_resp && nowr1)
        |=> s_bump1_c1)
        else $error("snoop response not counted");

    home_sum_a: assert property (
        (es1.en && code1 == PEC_EV_HOME_REQ && um1 == 8'h0F && ev_i.home_local_read && ev_i.home_remote_read
         && ev_i.home_local_write_cached && ev_i.home_remote_write_uncached && nowr1)
        |=> st_r.ctr[1] == $past(st_r.ctr[1]) + 32'h4)
        else $error("home requests not summed");

    ctr_preset_a: assert property (
        (wr_i && addr_i == PEC_CTR_BASE + PEC_REG_STRIDE)
        |=> st_r.ctr[1] == $past(wdata_i))
        else $error("counter write lost to a count");

    read_resp_a: assert property (
        (rd_i && addr_i == PEC_STATUS_ADDR) |=> rdata_o == {30'h0, $past(st_r.running), $past(st_r.active)})
        else $error("status read data wrong");
endmodule

// File: dv/test_pec_counter_logic.sv
module test_pec_counter_logic;
    timeunit 1ns;
    timeprecision 100ps;
    import pec_pkg::*;

    localparam logic [7:0] RATIO = 8'h02;   // short bus period keeps runs brief

    // design ports
    logic                   core_clk_i;
    logic                   reset_i;
    logic [PEC_AW-1:0]      addr_i;
    logic [PEC_DW-1:0]      wdata_i;
    logic                   wr_i;
    logic                   rd_i;
    logic [PEC_DW-1:0]      rdata_o;
    pec_events_t            ev_i;
    logic                   core_active_o;

    // bench state
    int                     bad_count;
    int                     cmp_count;
    int                     ecnt;
    logic                   prev_act;
    logic [31:0]            mdl [2];
    pec_evtsel_t            msel [2];
    logic [$bits(pec_events_t)-1:0] rnd_ev;
    // select pairs, counter 0 first; counter 0 carries every code that its in-design checks watch
    logic [16:0]            sels [20] = '{17'h1003C, 17'h10030, 17'h1013C, 17'h10032, 17'h1023C, 17'h1C032,
                                          17'h1C030, 17'h1004F, 17'h1007D, 17'h10178, 17'h12062, 17'h10077,
                                          17'h10420, 17'h10062, 17'h1012F, 17'h10F20, 17'h1012C, 17'h1013C,
                                          17'h0003C, 17'h1014F};

    pec_counter_logic #(.BUS_RATIO(RATIO)) u_dut (
        .core_clk_i    (core_clk_i),
        .reset_i       (reset_i),
        .addr_i        (addr_i),
        .wdata_i       (wdata_i),
        .wr_i          (wr_i),
        .rd_i          (rd_i),
        .rdata_o       (rdata_o),
        .ev_i          (ev_i),
        .core_active_o (core_active_o)
    );

    // 100 MHz core clock
    always #5 core_clk_i = ~core_clk_i;

    // increment one select should see in one cycle
    function automatic logic [31:0] exp_inc(pec_evtsel_t s, pec_events_t e, logic t);
        logic        act;
        logic        all;
        logic [31:0] n;
        act = e.core_running | e.core_snooped;
        all = (s.umask[7:6] == PEC_SPEC_ALL);
        n = 32'h0;
        if (s.en) begin
            case (s.code)
                // cycle events: a condition seen by both cores is still one cycle
                PEC_EV_L2_REJECT: if (act) n = 32'(e.l2_reject | (all & e.l2_reject_other));
                PEC_EV_L2_IDLE:   if (act) n = 32'(e.l2_idle | (all & e.l2_idle_other));
                PEC_EV_UNHALTED: begin
                    // halted core never counts here, even while snooped
                    if (e.core_running && s.umask == PEC_UM_00) n = 32'h1;
                    if (e.core_running && s.umask == PEC_UM_01) n = 32'(t);
                    if (e.core_running && s.umask == PEC_UM_02) n = 32'(t & e.other_halted);
                end
                PEC_EV_L1_PREF:   if (act && s.umask == PEC_UM_00) n = 32'(e.first_level_prefetch_requests);
                PEC_EV_SHR_SNOOP: if (act && s.umask == PEC_UM_01) n = 32'(e.data_cache_share_snoops);
                PEC_EV_BUS_IDLE:  if (act && s.umask == PEC_UM_00) n = 32'(e.bus_idle & t);
                PEC_EV_BUS_SNOOP: if (act && s.umask == PEC_UM_00) n = 32'(e.bus_snoop_resp);
                PEC_EV_BUS_DRDY:  if (act) n = 32'(e.bus_drdy | ((s.umask == PEC_UM_ALL_AG) & e.bus_drdy_other));
                PEC_EV_HOME_REQ:  n = 32'(s.umask[0] & (e.home_local_read | e.home_local_inv_excl))
                                    + 32'(s.umask[1] & (e.home_remote_read | e.home_remote_inv_excl))
                                    + 32'(s.umask[2] & e.home_local_write_cached)
                                    + 32'(s.umask[3] & e.home_remote_write_uncached);
                PEC_EV_MC_READ:   n = 32'(s.umask[0] & e.mc_normal_read);
                PEC_EV_MC_WRITE:  n = 32'(s.umask[0] & e.mc_write_cached_wb) + 32'(s.umask[0] & e.mc_write_uncached);
                default:          n = 32'h0;
            endcase
        end
        return n;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %08h expected %08h", $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge core_clk_i);
        wr_i    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe, then return to zero
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge core_clk_i);
        rd_i   <= 1'b0;
        #1 chk(rdata_o, exp);
        @(posedge core_clk_i);
        #1 chk(rdata_o, 32'h0);
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // reference counters and bus tick track the design every edge
    always @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ecnt     = 0;
            prev_act = 1'b0;
        end else begin
            if (ecnt >= 1) chk({31'h0, core_active_o}, {31'h0, prev_act});
            for (int i = 0; i < 2; i++) begin
                mdl[i] = mdl[i] + exp_inc(msel[i], ev_i, ecnt >= 1 && (ecnt - 1) % RATIO == 0);
            end
            prev_act = ev_i.core_running | ev_i.core_snooped;
            ecnt++;
        end
    end

    // watchdog against a hung run
    initial begin
        #200us;
        bad_count++;
        close_out();
    end

    initial begin
        logic [31:0] junk;
        pec_evtsel_t s;
        core_clk_i = 1'b0;
        reset_i    = 1'b1;
        addr_i     = '0;
        wdata_i    = '0;
        wr_i       = 1'b0;
        rd_i       = 1'b0;
        ev_i       = '0;
        bad_count  = 0;
        cmp_count  = 0;
        mdl        = '{32'h0, 32'h0};
        msel       = '{'0, '0};
        void'($urandom(32'hA170C652));
        repeat (16) @(posedge core_clk_i);
        reset_i <= 1'b0;
        // reset values: select 0 and counter 1 read as clear
        reg_rd(PEC_EVTSEL_BASE, 32'h0);
        reg_rd(PEC_CTR_BASE + PEC_REG_STRIDE, 32'h0);
        for (int t = 0; t < 10; t++) begin
            for (int i = 0; i < 2; i++) begin
                s       = '0;
                s.en    = sels[2*t+i][16];
                s.umask = sels[2*t+i][15:8];
                s.code  = sels[2*t+i][7:0];
                junk    = $urandom();
                // stray reserved bits are written and must read back as zero
                reg_wr(PEC_EVTSEL_BASE + 8'(i * 4), {junk[31:23], s.en, junk[21:16], s.umask, s.code});
                msel[i] = s;
                reg_rd(PEC_EVTSEL_BASE + 8'(i * 4), {9'h0, s.en, 6'h0, s.umask, s.code});
                junk = $urandom();
                reg_wr(PEC_CTR_BASE + 8'(i * 4), junk);
                mdl[i] = junk;
            end
            for (int c = 0; c < 60; c++) begin
                @(posedge core_clk_i);
                rnd_ev = $bits(pec_events_t)'($urandom());
                // a stretch of halted but snooped cycles in every run
                if (c >= 20 && c < 30) begin
                    rnd_ev[$bits(pec_events_t)-1] = 1'b0;
                    rnd_ev[$bits(pec_events_t)-2] = 1'b1;
                end
                ev_i <= pec_events_t'(rnd_ev);
            end
            @(posedge core_clk_i);
            ev_i <= '0;
            repeat (2) @(posedge core_clk_i);
            reg_rd(PEC_CTR_BASE, mdl[0]);
            reg_rd(PEC_CTR_BASE + PEC_REG_STRIDE, mdl[1]);
            $display("test %0d done", t);
        end
        // unmapped places: write ignored, read zero
        reg_wr(8'h44, 32'hFFFFFFFF);
        reg_rd(8'h44, 32'h0);
        reg_rd(8'h80, 32'h0);
        reg_rd(PEC_CTR_BASE, mdl[0]);
        // status view of running and snooped core
        @(posedge core_clk_i);
        ev_i <= pec_events_t'({1'b1, {($bits(pec_events_t)-1){1'b0}}});
        repeat (3) @(posedge core_clk_i);
        reg_rd(PEC_STATUS_ADDR, 32'h3);
        @(posedge core_clk_i);
        ev_i <= pec_events_t'({2'b01, {($bits(pec_events_t)-2){1'b0}}});
        repeat (3) @(posedge core_clk_i);
        reg_rd(PEC_STATUS_ADDR, 32'h1);
        @(posedge core_clk_i);
        ev_i <= '0;
        $display("test status done");
        close_out();
    end
endmodule
